// ==== ext_stack_pkg.sv ====
// constants and types for the extended stack instruction unit
package ext_stack_pkg;
    localparam int ADDR_W = 12;
    localparam int PC_W = 21;
    localparam logic [7:0] OP_ADD_PTR = 8'hE8;
    localparam logic [7:0] OP_SUB_PTR = 8'hE9;
    localparam logic [7:0] OP_PUSH_LIT = 8'hEA;
    localparam logic [7:0] OP_MOVE_IDX = 8'hEB;
    localparam logic [15:0] OP_CALL_IND = 16'h0014;
    localparam logic [3:0] SECOND_WORD_PREFIX = 4'hF;
    localparam logic [1:0] FRAME_SEL = 2'h3;
    localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    // indirect access registers sit in this address window
    localparam logic [ADDR_W-1:0] INDIRECT_LOW = 12'hFDB;
    localparam logic [ADDR_W-1:0] INDIRECT_HIGH = 12'hFEF;
    // three plain registers sit between each group of five indirect ones
    localparam logic [2:0] INDIRECT_SLOT_MIN = 3'h3;
    localparam int NUM_PTR = 3;
    localparam int FRAME_IDX = 2;
    localparam int UPPER_W = PC_W - 16;
    localparam int BYTE_W = 8;
    localparam int LIT_W = 6;
    localparam int OFFSET_W = 7;
    localparam int IDX_FLAG_BIT = 7;
    localparam logic [ADDR_W-1:0] PTR_RESET = 12'h000;
    localparam logic [ADDR_W-1:0] PTR_STEP = 12'h001;
    localparam logic [ADDR_W-1:0] ADDR_ZERO = 12'h000;
    localparam logic [PC_W-1:0] PC_ZERO = 21'h000000;
    typedef enum logic [1:0] {
        ST_FETCH = 2'b00,
        ST_IDLE2 = 2'b01,
        ST_MOVE2 = 2'b10
    } state_type;
endpackage : ext_stack_pkg

// ==== extended_stack_instruction_unit.sv ====
// decode and execution control for the extended stack instructions
module extended_stack_instruction_unit (
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // configuration
    input wire logic extendedSetEnable,
    // instruction fetch
    input wire logic instrValid,
    input wire logic [15:0] instrWord,
    input wire logic [ext_stack_pkg::PC_W-1:0] programCounter,
    // core state
    input wire logic [7:0] workingRegister,
    input wire logic [7:0] counterHighLatch,
    input wire logic [7:0] counterUpperLatch,
    input wire logic [ext_stack_pkg::PC_W-1:0] returnStackTop,
    input wire logic [7:0] memReadData,
    // pointer outputs
    output logic [ext_stack_pkg::ADDR_W-1:0] filePointer0,
    output logic [ext_stack_pkg::ADDR_W-1:0] filePointer1,
    output logic [ext_stack_pkg::ADDR_W-1:0] framePointer,
    // data memory
    output logic memRead,
    output logic [ext_stack_pkg::ADDR_W-1:0] memReadAddr,
    output logic memWrite,
    output logic [ext_stack_pkg::ADDR_W-1:0] memWriteAddr,
    output logic [7:0] memWriteData,
    // program flow
    output logic pcLoad,
    output logic [ext_stack_pkg::PC_W-1:0] pcLoadValue,
    output logic stackPush,
    output logic [ext_stack_pkg::PC_W-1:0] stackPushValue,
    output logic stackPop,
    output logic busy
);
    import ext_stack_pkg::*;

    // ----------------------------------------
    // decode
    // ----------------------------------------
    state_type state;
    logic [7:0] opHigh;
    logic [1:0] sel;
    logic [ADDR_W-1:0] lit6;
    logic [ADDR_W-1:0] srcAddr;
    logic [ADDR_W-1:0] dstIdxAddr;
    logic [ADDR_W-1:0] moveDst;
    logic isFetch;
    logic enabled;
    logic isAddSub;
    logic isUnlink;
    logic isPush;
    logic isCall;
    logic isMove;
    logic moveDone;
    logic dstBlocked;
    logic movedIdx;
    logic [BYTE_W-1:0] srcByte;

    function automatic logic isIndirect(input logic [ADDR_W-1:0] a);
        // groups of five indirect slots with three plain registers between
        isIndirect = (a >= INDIRECT_LOW) && (a <= INDIRECT_HIGH) && (a[2:0] >= INDIRECT_SLOT_MIN);
    endfunction : isIndirect

    assign opHigh = instrWord[15:8];
    assign sel = instrWord[7:6];
    assign lit6 = ADDR_W'(instrWord[LIT_W-1:0]);
    assign isFetch = (state == ST_FETCH) && instrValid;
    assign enabled = isFetch && extendedSetEnable;
    assign isAddSub = enabled && (opHigh == OP_ADD_PTR || opHigh == OP_SUB_PTR);
    assign isUnlink = isAddSub && (sel == FRAME_SEL);
    assign isPush = enabled && (opHigh == OP_PUSH_LIT);
    assign isCall = enabled && (instrWord == OP_CALL_IND);
    assign isMove = enabled && (opHigh == OP_MOVE_IDX);
    // offsets are unsigned, so a frame near the top wraps round the data space
    assign srcAddr = framePointer + ADDR_W'(instrWord[OFFSET_W-1:0]);
    assign dstIdxAddr = framePointer + ADDR_W'(instrWord[OFFSET_W-1:0]);
    assign moveDone = (state == ST_MOVE2) && instrValid;
    // second word carries either a full address or a frame offset
    assign moveDst = movedIdx ? dstIdxAddr : instrWord[ADDR_W-1:0];
    assign dstBlocked = movedIdx && isIndirect(dstIdxAddr);
    // an indirect source reads as zero, never through the indirect path
    assign srcByte = isIndirect(memReadAddr) ? ZERO_BYTE : memReadData;

    // ----------------------------------------
    // pointers
    // ----------------------------------------
    // plain wrapping adders: no carry or zero flag leaves this block
    for (genvar g = 0; g < NUM_PTR; g++) begin : g_ptr
        logic [ADDR_W-1:0] value;
        logic selHit;
        assign selHit = isAddSub && ((sel == 2'(g)) || (isUnlink && g == FRAME_IDX));
        always_ff @(posedge clk_sys or negedge arst_n) begin
            if (!arst_n) begin
                value <= PTR_RESET;
            end else if (selHit && opHigh == OP_ADD_PTR) begin
                value <= value + lit6;
            end else if (selHit && opHigh == OP_SUB_PTR) begin
                value <= value - lit6;
            end else if (g == FRAME_IDX && isPush) begin
                value <= value - PTR_STEP;
            end
        end
    end : g_ptr

    assign filePointer0 = g_ptr[0].value;
    assign filePointer1 = g_ptr[1].value;
    assign framePointer = g_ptr[FRAME_IDX].value;

    // ----------------------------------------
    // sequencing
    // ----------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state <= ST_FETCH;
        end else begin
            case (state)
                ST_FETCH: begin
                    if (isUnlink) begin
                        state <= ST_IDLE2;
                    end else if (isCall) begin
                        state <= ST_IDLE2;
                    end else if (isMove) begin
                        state <= ST_MOVE2;
                    end
                end
                ST_IDLE2: begin
                    // word fetched now is the target, so nothing is decoded
                    state <= ST_FETCH;
                end
                ST_MOVE2: begin
                    if (instrValid) begin
                        state <= ST_FETCH;
                    end
                end
                default: begin
                    state <= ST_FETCH;
                end
            endcase
        end
    end

    // ----------------------------------------
    // data read port
    // ----------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            memRead <= 1'b0;
            memReadAddr <= ADDR_ZERO;
            movedIdx <= 1'b0;
        end else if (isMove) begin
            // no access at all when the source is an indirect register
            memRead <= !isIndirect(srcAddr);
            memReadAddr <= srcAddr;
            movedIdx <= instrWord[IDX_FLAG_BIT];
        end else if (moveDone) begin
            memRead <= 1'b0;
        end
    end

    // ----------------------------------------
    // data write port
    // ----------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            memWrite <= 1'b0;
            memWriteAddr <= ADDR_ZERO;
            memWriteData <= ZERO_BYTE;
        end else if (isPush) begin
            memWrite <= 1'b1;
            memWriteAddr <= framePointer;
            memWriteData <= instrWord[BYTE_W-1:0];
        end else if (moveDone) begin
            // a blocked destination turns the move into a no-operation
            memWrite <= !dstBlocked;
            memWriteAddr <= moveDst;
            memWriteData <= srcByte;
        end else begin
            memWrite <= 1'b0;
        end
    end

    // ----------------------------------------
    // program flow
    // ----------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pcLoad <= 1'b0;
            pcLoadValue <= PC_ZERO;
        end else if (isCall) begin
            pcLoad <= 1'b1;
            pcLoadValue <= {counterUpperLatch[UPPER_W-1:0], counterHighLatch, workingRegister};
        end else if (isUnlink) begin
            pcLoad <= 1'b1;
            pcLoadValue <= returnStackTop;
        end else begin
            pcLoad <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            stackPush <= 1'b0;
            stackPushValue <= PC_ZERO;
            stackPop <= 1'b0;
        end else begin
            stackPush <= isCall;
            stackPop <= isUnlink;
            if (isCall) begin
                stackPushValue <= programCounter + PC_STEP;
            end
        end
    end

    // call saves nothing else: working, status and bank stay with the core
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            busy <= 1'b0;
        end else if (isUnlink || isCall || isMove) begin
            busy <= 1'b1;
        end else if (state == ST_IDLE2 || moveDone) begin
            busy <= 1'b0;
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb_sys @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);

    sequence s_quiet;
        !memWrite && !stackPush && !stackPop && !pcLoad && !busy;
    endsequence

    sequence s_call_issue;
        stackPush && pcLoad && busy && stackPushValue == $past(programCounter) + PC_STEP;
    endsequence

    a_call_two_cycles: assert property (
        isCall |=> s_call_issue ##1 s_quiet)
        else $error("call did not push and then idle one cycle");

    a_call_target: assert property (
        isCall |=> pcLoadValue == $past({counterUpperLatch[UPPER_W-1:0], counterHighLatch, workingRegister}))
        else $error("call target not built from latches and working register");

    a_unlink_return: assert property (
        isUnlink |=> pcLoad && stackPop && pcLoadValue == $past(returnStackTop) ##1 s_quiet)
        else $error("frame adjust did not return through the stack top");

    a_push_step: assert property (
        isPush |=> memWrite && memWriteAddr == $past(framePointer)
            && memWriteData == $past(instrWord[BYTE_W-1:0]) && framePointer == $past(framePointer) - PTR_STEP)
        else $error("push literal did not write and step the frame pointer");

    a_ext_disabled: assert property (
        instrValid && state == ST_FETCH && !extendedSetEnable |=> $stable(framePointer)
            && !memWrite && !pcLoad && !stackPush && !busy)
        else $error("extended instruction acted while the set is off");

    a_dest_blocked: assert property (
        moveDone && dstBlocked |=> !memWrite)
        else $error("indexed move wrote to an indirect register");

    a_stray_word: assert property (
        enabled && instrWord[15:12] == SECOND_WORD_PREFIX |=> s_quiet)
        else $error("stray second word was not a no-operation");
endmodule : extended_stack_instruction_unit

// ==== core_partner.sv ====
// behavioural core partner: return stack and data read port
module core_partner (
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // requests
    input wire logic stackPush,
    input wire logic [ext_stack_pkg::PC_W-1:0] stackPushValue,
    input wire logic memRead,
    input wire logic [ext_stack_pkg::ADDR_W-1:0] memReadAddr,
    // answers
    output logic [ext_stack_pkg::PC_W-1:0] returnStackTop,
    output logic [7:0] memReadData
);
    timeunit 1ns;
    timeprecision 1ns;
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) returnStackTop <= 21'h000100;
        else if (stackPush) returnStackTop <= stackPushValue;
    end
    // read data stands while the request stands; idle port shows all ones
    always_comb memReadData = memRead ? (memReadAddr[7:0] ^ 8'hA5) : 8'hFF;
endmodule : core_partner

// ==== tb.sv ====
// self-checking bench for the extended stack instruction unit
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import ext_stack_pkg::*;
    logic clk_sys = 0, arst_n = 0, extendedSetEnable = 1, instrValid = 0;
    logic [15:0] instrWord = 16'h0000;
    logic [PC_W-1:0] programCounter = 21'h000100, returnStackTop, pcLoadValue, stackPushValue, pcSeen, pushSeen;
    logic [7:0] workingRegister = 8'h06, counterHighLatch = 8'h10, counterUpperLatch = 8'h00;
    logic [7:0] memReadData, memWriteData, dataSeen;
    logic [ADDR_W-1:0] filePointer0, filePointer1, framePointer, memReadAddr, memWriteAddr, addrSeen, p;
    logic memRead, memWrite, pcLoad, stackPush, stackPop, busy;
    logic [6:0] z;
    int n_errors = 0, checked = 0, writes = 0, loads = 0, busyCycles = 0;
    always #10 clk_sys = ~clk_sys;
    extended_stack_instruction_unit u_dut (.clk_sys, .arst_n, .extendedSetEnable, .instrValid, .instrWord,
        .programCounter, .workingRegister, .counterHighLatch, .counterUpperLatch, .returnStackTop, .memReadData,
        .filePointer0, .filePointer1, .framePointer, .memRead, .memReadAddr, .memWrite, .memWriteAddr,
        .memWriteData, .pcLoad, .pcLoadValue, .stackPush, .stackPushValue, .stackPop, .busy);
    core_partner u_core (.clk_sys, .arst_n, .stackPush, .stackPushValue, .memRead, .memReadAddr,
        .returnStackTop, .memReadData);
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // fixed ten-cycle window: each one-cycle pulse is caught at a falling edge
    task automatic run(input logic [15:0] w, input logic [15:0] w2 = 16'h0000, input bit twoWords = 1'b0);
        writes = 0;
        loads = 0;
        busyCycles = 0;
        @(negedge clk_sys) {instrValid, instrWord} = {1'b1, w};
        if (twoWords) @(negedge clk_sys) instrWord = w2;
        for (int i = 0; i < 10; i++) begin
            @(negedge clk_sys) instrValid = 0;
            if (memWrite === 1'b1) begin
                writes++;
                {addrSeen, dataSeen} = {memWriteAddr, memWriteData};
            end
            if (pcLoad === 1'b1) begin
                loads++;
                pcSeen = pcLoadValue;
            end
            if (stackPush === 1'b1) pushSeen = stackPushValue;
            if (busy === 1'b1) busyCycles++;
        end
    endtask : run
    task automatic t_pointers;
        p = filePointer0;
        run(16'hE83F);
        check("fp0 add", filePointer0, 12'(p + 12'h03F));
        check("fp1 kept", filePointer1, 12'h000);
        p = framePointer;
        run(16'hE9BF);
        check("frame sub wrap", framePointer, 12'(p - 12'h03F));
    endtask : t_pointers
    task automatic t_push;
        p = framePointer;
        run(16'hEA5A);
        check("push addr", addrSeen, p);
        check("push data", dataSeen, 8'h5A);
        check("push dec", framePointer, 12'(p - 12'h001));
        check("push writes", writes, 1);
    endtask : t_push
    task automatic t_call;
        run(OP_CALL_IND);
        check("call ret", pushSeen, 21'h000102);
        check("call pc", pcSeen, 21'h001006);
        check("call busy", busyCycles, 1);
        check("call loads", loads, 1);
    endtask : t_call
    task automatic t_unlink;
        p = framePointer;
        run(16'hE8C1);
        check("ulnk fp", framePointer, 12'(p + 12'h001));
        check("ulnk busy", busyCycles, 1);
        check("ulnk pc", pcSeen, 21'h000102);
        p = framePointer;
        run(16'hE9C2);
        check("sub ulnk fp", framePointer, 12'(p - 12'h002));
        check("sub ulnk pc", pcSeen, 21'h000102);
        check("sub ulnk loads", loads, 1);
    endtask : t_unlink
    task automatic t_moves;
        p = framePointer;
        // destination kept clear of counter low and stack top bytes
        run(16'hEB05, 16'hF123, 1'b1);
        check("indexed_to_file_move addr", addrSeen, 12'h123);
        p = 12'(p + 12'h005);
        check("indexed_to_file_move data", dataSeen, p[7:0] ^ 8'hA5);
        run(16'hEB85, 16'hF006, 1'b1);
        check("indexed_to_indexed_move addr", addrSeen, 12'(framePointer + 12'h006));
        check("indexed_to_indexed_move data", dataSeen, p[7:0] ^ 8'hA5);
        z = 7'(INDIRECT_LOW - framePointer);
        run({8'hEB, 1'b0, z}, 16'hF123, 1'b1);
        check("indirect src", dataSeen, 8'h00);
        run(16'hEB80, {4'hF, 5'h00, z}, 1'b1);
        check("indirect dst", writes, 0);
    endtask : t_moves
    task automatic t_stray;
        p = framePointer;
        run(16'hF0A5);
        check("stray writes", writes, 0);
        check("stray loads", loads, 0);
        check("stray fp", framePointer, p);
    endtask : t_stray
    task automatic t_disabled;
        extendedSetEnable = 0;
        p = framePointer;
        run(16'hE8C5);
        check("off fp", framePointer, p);
        check("off loads", loads, 0);
    endtask : t_disabled
    task automatic end_of_test;
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : end_of_test
    initial begin
        repeat (8) @(negedge clk_sys);
        arst_n = 1;
        t_pointers();
        t_push();
        t_call();
        t_unlink();
        t_moves();
        t_stray();
        t_disabled();
        end_of_test();
    end
endmodule : tb
